// ===== rtl/ipcr_pkg.sv
// Constants, states and register layout of the plug and play config bank.
// Assumes one bus clock domain shared by the ISA strobes and the bank.
package ipcr_pkg;

   typedef enum logic [1:0] {ST_WAIT_KEY, ST_SLEEP, ST_ISOLATE, ST_CONFIG} ipcr_state_e;

   // Fixed ISA ports and read port top and low bits
   localparam logic [15:0] ADDR_PORT      = 16'h0279;
   localparam logic [15:0] WDATA_PORT     = 16'h0A79;
   localparam logic [1:0]  RDPORT_LOW     = 2'h3;
   localparam logic [5:0]  RDPORT_TOP     = 6'h00;

   // Card control indices
   localparam logic [7:0]  IDX_RDPORT     = 8'h00;
   localparam logic [7:0]  IDX_ISOLATE    = 8'h01;
   localparam logic [7:0]  IDX_CTRL       = 8'h02;
   localparam logic [7:0]  IDX_WAKE       = 8'h03;
   localparam logic [7:0]  IDX_RES_DATA   = 8'h04;
   localparam logic [7:0]  IDX_STATUS     = 8'h05;
   localparam logic [7:0]  IDX_CSN        = 8'h06;
   localparam logic [7:0]  IDX_LDN        = 8'h07;
   localparam logic [7:0]  IDX_MEMCTL     = 8'h42;
   localparam logic [7:0]  IDX_IRQ_TYPE   = 8'h71;
   localparam logic [7:0]  IDX_SAVED_CSN  = 8'hF5;

   // Control register command bits and status ready bit
   localparam int          CC_RESET_BIT   = 0;
   localparam int          CC_WAITKEY_BIT = 1;
   localparam int          CC_CSNCLR_BIT  = 2;
   localparam int          STATUS_RDY_BIT = 0;

   // Fixed read values and reset values
   localparam logic [7:0]  LDN_VALUE      = 8'h00;
   localparam logic [7:0]  MEMCTL_VALUE   = 8'h00;
   localparam logic [7:0]  IRQ_TYPE_VALUE = 8'h02;
   localparam logic [7:0]  RCHK_PAT_SET   = 8'h55;
   localparam logic [7:0]  RCHK_PAT_CLR   = 8'hAA;
   localparam logic [7:0]  CSN_RST        = 8'h00;
   localparam logic [7:0]  RDPORT_RST     = 8'h00;

   // Logical device configuration registers, one entry each
   localparam int          CFG_N          = 7;
   localparam int          CFG_ACT        = 0;
   localparam int          CFG_RCHK       = 1;
   localparam int          CFG_ROM_HI     = 2;
   localparam int          CFG_ROM_LO     = 3;
   localparam int          CFG_IO_HI      = 4;
   localparam int          CFG_IO_LO      = 5;
   localparam int          CFG_IRQ        = 6;
   localparam int          ACT_BIT        = 0;
   localparam int          RCHK_EN_BIT    = 1;
   localparam int          RCHK_PAT_BIT   = 0;
   localparam logic [7:0]  CFG_INDEX [CFG_N] = '{8'h30, 8'h31, 8'h40, 8'h41, 8'h60, 8'h61, 8'h70};
   localparam logic [7:0]  CFG_MASK  [CFG_N] = '{8'h01, 8'h03, 8'h0D, 8'hC0, 8'h03, 8'hE0, 8'h0F};
   localparam logic [7:0]  CFG_RST   [CFG_N] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

   localparam int          IO_RANGE_LOG2_MAX = 5;

endpackage

// ===== rtl/ipcr_res_reader.sv
// Resource data prefetcher: keeps one byte ready for the host to read.
// Assumes the byte store answers with a one-cycle ack while fetch_req is high.
`timescale 1ns/1ns
module ipcr_res_reader #(
   parameter int PTR_W = 9
) (
   // Clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   // Control from the register bank
   input  wire logic             i_restart,
   input  wire logic             i_take,
   output logic                  o_ready,
   output logic [7:0]            o_byte,
   // Byte store
   output logic                  o_fetch_req,
   output logic [PTR_W-1:0]      o_fetch_addr,
   input  wire logic             i_fetch_ack,
   input  wire logic [7:0]       i_fetch_byte
);
   logic             have_ff;
   logic [7:0]       byte_ff;
   logic [PTR_W-1:0] ptr_ff;
   logic             nxt_have;
   logic [7:0]       nxt_byte;
   logic [PTR_W-1:0] nxt_ptr;
   logic             load;

   if (PTR_W < 1 || PTR_W > 16) begin : g_chk
      $error("PTR_W must be 1 to 16");
   end

   // Ack ignored while holding a byte, so load and take never collide
   assign load     = i_fetch_ack && !have_ff && !i_restart;
   assign nxt_have = i_restart ? 1'b0 : (load ? 1'b1 : (i_take ? 1'b0 : have_ff));
   assign nxt_byte = load ? i_fetch_byte : byte_ff;
   assign nxt_ptr  = i_restart ? '0 : (load ? ptr_ff + 1'b1 : ptr_ff);

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         have_ff <= 1'b0;
         byte_ff <= 8'h00;
         ptr_ff  <= '0;
      end else begin
         have_ff <= nxt_have;
         byte_ff <= nxt_byte;
         ptr_ff  <= nxt_ptr;
      end
   end

   assign o_ready      = have_ff;
   assign o_byte       = byte_ff;
   assign o_fetch_req  = !have_ff;
   assign o_fetch_addr = ptr_ff;

endmodule

// ===== rtl/ipcr_top.sv
// Plug and play card and logical device register bank behind the ISA ports.
// Assumes ISA strobes are one-cycle pulses already in the bus clock domain,
// and that key decoding, serial id logic and the byte store sit outside.
`timescale 1ns/1ns
module ipcr_top
   import ipcr_pkg::*;
#(
   parameter int RES_PTR_W     = 9,
   parameter int IO_RANGE_LOG2 = 5,
   parameter int ROM_SIZE_W    = 2
) (
   // Clock and reset
   input  wire logic                  i_clk,
   input  wire logic                  i_rst,
   // ISA I/O cycle
   input  wire logic [15:0]           i_io_addr,
   input  wire logic [7:0]            i_io_wdata,
   input  wire logic                  i_io_wr,
   input  wire logic                  i_io_rd,
   output logic [7:0]                 o_io_rdata,
   output logic                       o_io_rd_drive,
   // Initiation key and isolation helpers
   input  wire logic                  i_key_match,
   output logic                       o_iso_compare,
   input  wire logic [7:0]            i_iso_bit_data,
   // Resource byte store
   output logic                       o_res_fetch_req,
   output logic [RES_PTR_W-1:0]       o_res_fetch_addr,
   input  wire logic                  i_res_fetch_ack,
   input  wire logic [7:0]            i_res_fetch_byte,
   // EEPROM settings
   input  wire logic [ROM_SIZE_W-1:0] i_rom_size_cfg,
   // Configuration seen by the rest of the card
   output ipcr_pkg::ipcr_state_e      o_card_state,
   output logic                       o_dev_active,
   output logic [15:0]                o_io_base,
   output logic [3:0]                 o_irq_level,
   output logic                       o_irq_selected,
   output logic [23:8]                o_boot_rom_base,
   output logic [ROM_SIZE_W-1:0]      o_boot_rom_size,
   output logic [7:0]                 o_card_number,
   output logic [7:0]                 o_saved_card_number
);
   import ipcr_pkg::*;

   if (IO_RANGE_LOG2 < 1 || IO_RANGE_LOG2 > IO_RANGE_LOG2_MAX) begin : g_chk_range
      $error("IO_RANGE_LOG2 must be 1 to 5");
   end
   if (ROM_SIZE_W < 1) begin : g_chk_rom
      $error("ROM_SIZE_W must be at least 1");
   end
   if (RES_PTR_W < 1 || RES_PTR_W > 16) begin : g_chk_ptr
      $error("RES_PTR_W must be 1 to 16");
   end

   ipcr_state_e           state_ff;
   ipcr_state_e           nxt_state;
   logic [7:0]            index_ff;
   logic [7:0]            rd_port_ff;
   logic [7:0]            csn_ff;
   logic [7:0]            saved_ff;
   logic [7:0]            cfg_ff  [CFG_N];
   logic [7:0]            cfg_acc [CFG_N+1];
   logic [7:0]            rdata_ff;
   logic                  drive_ff;
   logic [ROM_SIZE_W-1:0] rom_size_ff;
   logic [7:0]            nxt_index;
   logic [7:0]            nxt_rd_port;
   logic [7:0]            nxt_csn;
   logic [7:0]            nxt_saved;
   logic [7:0]            nxt_rdata;
   logic                  nxt_drive;

   // Address decode
   logic        pnp_en;
   logic        in_sleep;
   logic        in_iso;
   logic        in_cfg;
   logic        hit_addr_port;
   logic        hit_wdata_port;
   logic        hit_rdport;
   logic        hit_range;
   logic        wr_idx;
   logic        wr_dat;
   logic        wr_rdport;
   logic        wr_ctrl;
   logic        wr_wake;
   logic        wr_csn;
   logic        wr_cfg;
   logic        cmd_reset;
   logic        cmd_wait_key;
   logic        cmd_csn_clr;
   logic        wake_match;
   logic        rd_pnp;
   logic        rd_range;
   logic        range_active;
   logic        rchk_pat;
   logic        res_ready;
   logic        res_take;
   logic [7:0]  res_byte;
   logic [7:0]  rd_value;

   assign pnp_en         = state_ff != ST_WAIT_KEY;
   assign in_sleep       = state_ff == ST_SLEEP;
   assign in_iso         = state_ff == ST_ISOLATE;
   assign in_cfg         = state_ff == ST_CONFIG;
   assign hit_addr_port  = i_io_addr == ADDR_PORT;
   assign hit_wdata_port = i_io_addr == WDATA_PORT;
   assign hit_rdport     = i_io_addr == {RDPORT_TOP, rd_port_ff, RDPORT_LOW};
   assign hit_range      = i_io_addr[15:IO_RANGE_LOG2] == o_io_base[15:IO_RANGE_LOG2];

   // Writes to the address port in the key state go to the key decoder only
   assign wr_idx    = i_io_wr && hit_addr_port && pnp_en;
   assign wr_dat    = i_io_wr && hit_wdata_port && pnp_en;
   assign wr_rdport = wr_dat && (index_ff == IDX_RDPORT) && (in_iso || in_cfg);
   assign wr_ctrl   = wr_dat && (index_ff == IDX_CTRL);
   assign wr_wake   = wr_dat && (index_ff == IDX_WAKE);
   assign wr_csn    = wr_dat && (index_ff == IDX_CSN) && (in_iso || in_cfg);
   assign wr_cfg    = wr_dat && in_cfg;

   // Commands are pulses, nothing is stored, so they always read back clear
   assign cmd_reset    = wr_ctrl && i_io_wdata[CC_RESET_BIT];
   assign cmd_wait_key = wr_ctrl && i_io_wdata[CC_WAITKEY_BIT];
   assign cmd_csn_clr  = wr_ctrl && i_io_wdata[CC_CSNCLR_BIT];
   assign wake_match   = wr_wake && in_sleep && (i_io_wdata == csn_ff);

   assign nxt_index   = wr_idx ? i_io_wdata : index_ff;
   assign nxt_rd_port = wr_rdport ? i_io_wdata : rd_port_ff;
   assign nxt_csn     = cmd_csn_clr ? CSN_RST : (wr_csn ? i_io_wdata : csn_ff);
   assign nxt_saved   = cmd_csn_clr ? CSN_RST : (wr_csn ? i_io_wdata : saved_ff);

   // Card state
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_WAIT_KEY: begin
            if (i_key_match) begin
               nxt_state = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (wake_match) begin
               nxt_state = (i_io_wdata == 8'h00) ? ST_ISOLATE : ST_CONFIG;
            end
         end
         ST_ISOLATE: begin
            if (wr_csn) begin
               nxt_state = ST_CONFIG;
            end
         end
         ST_CONFIG: begin
            nxt_state = ST_CONFIG;
         end
         default: begin
            nxt_state = ST_WAIT_KEY;
         end
      endcase
      if (cmd_wait_key) begin
         nxt_state = ST_WAIT_KEY;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state_ff   <= ST_WAIT_KEY;
         index_ff   <= IDX_RDPORT;
         rd_port_ff <= RDPORT_RST;
         csn_ff     <= CSN_RST;
         saved_ff   <= CSN_RST;
      end else begin
         state_ff   <= nxt_state;
         index_ff   <= nxt_index;
         rd_port_ff <= nxt_rd_port;
         csn_ff     <= nxt_csn;
         saved_ff   <= nxt_saved;
      end
   end

   // Logical device configuration registers; masked bits never store
   assign cfg_acc[0] = 8'h00;
   for (genvar k = 0; k < CFG_N; k++) begin : g_cfg
      logic       wr_k;
      logic [7:0] nxt_cfg;
      assign wr_k    = wr_cfg && (index_ff == CFG_INDEX[k]);
      assign nxt_cfg = cmd_reset ? CFG_RST[k] :
                       (wr_k ? (i_io_wdata & CFG_MASK[k]) : cfg_ff[k]);
      assign cfg_acc[k+1] = cfg_acc[k] | ((index_ff == CFG_INDEX[k]) ? cfg_ff[k] : 8'h00);
      always_ff @(posedge i_clk) begin
         if (i_rst) begin
            cfg_ff[k] <= CFG_RST[k];
         end else begin
            cfg_ff[k] <= nxt_cfg;
         end
      end
   end

   // Resource bytes, restarted from the first byte on every wake
   assign res_take = rd_pnp && (index_ff == IDX_RES_DATA) && res_ready;

   ipcr_res_reader #(
      .PTR_W (RES_PTR_W)
   ) u_res (
      .i_clk        (i_clk),
      .i_rst        (i_rst),
      .i_restart    (wake_match),
      .i_take       (res_take),
      .o_ready      (res_ready),
      .o_byte       (res_byte),
      .o_fetch_req  (o_res_fetch_req),
      .o_fetch_addr (o_res_fetch_addr),
      .i_fetch_ack  (i_res_fetch_ack),
      .i_fetch_byte (i_res_fetch_byte)
   );

   // Read path; unlisted indices fall through to the zero accumulator
   assign rd_value = (index_ff == IDX_ISOLATE)   ? (in_iso ? i_iso_bit_data : 8'h00) :
                     (index_ff == IDX_RES_DATA)  ? res_byte :
                     (index_ff == IDX_STATUS)    ? {7'h00, res_ready} :
                     (index_ff == IDX_CSN)       ? csn_ff :
                     (index_ff == IDX_LDN)       ? LDN_VALUE :
                     (index_ff == IDX_MEMCTL)    ? MEMCTL_VALUE :
                     (index_ff == IDX_IRQ_TYPE)  ? IRQ_TYPE_VALUE :
                     (index_ff == IDX_SAVED_CSN) ? saved_ff :
                     cfg_acc[CFG_N];

   assign rd_pnp        = i_io_rd && (in_iso || in_cfg) && hit_rdport;
   assign o_iso_compare = rd_pnp && in_iso && (index_ff == IDX_ISOLATE);
   // An active device ignores the enable, so a stale check cannot hijack reads
   assign range_active  = !o_dev_active && cfg_ff[CFG_RCHK][RCHK_EN_BIT];
   assign rchk_pat      = cfg_ff[CFG_RCHK][RCHK_PAT_BIT];
   assign rd_range      = i_io_rd && !rd_pnp && range_active && hit_range;
   assign nxt_rdata     = rd_pnp ? rd_value :
                          (rd_range ? (rchk_pat ? RCHK_PAT_SET : RCHK_PAT_CLR) : 8'h00);
   assign nxt_drive     = rd_pnp || rd_range;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         rdata_ff    <= 8'h00;
         drive_ff    <= 1'b0;
         rom_size_ff <= '0;
      end else begin
         rdata_ff    <= nxt_rdata;
         drive_ff    <= nxt_drive;
         rom_size_ff <= i_rom_size_cfg;
      end
   end

   assign o_io_rdata          = rdata_ff;
   assign o_io_rd_drive       = drive_ff;
   assign o_card_state        = state_ff;
   assign o_dev_active        = cfg_ff[CFG_ACT][ACT_BIT];
   assign o_io_base           = {cfg_ff[CFG_IO_HI], cfg_ff[CFG_IO_LO]};
   assign o_irq_level         = cfg_ff[CFG_IRQ][3:0];
   assign o_irq_selected      = cfg_ff[CFG_IRQ][3:0] != 4'h0;
   assign o_boot_rom_base     = {cfg_ff[CFG_ROM_HI], cfg_ff[CFG_ROM_LO]};
   assign o_boot_rom_size     = rom_size_ff;
   assign o_card_number       = csn_ff;
   assign o_saved_card_number = saved_ff;

   // Checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   a_index_kept: assert property (wr_dat |=> index_ff == $past(index_ff))
      else $error("index changed on a data port write");
   a_rdport_place: assert property (wr_rdport |=> rd_port_ff == $past(i_io_wdata))
      else $error("read port not placed");
   a_iso_answer: assert property (o_iso_compare |=>
      o_io_rd_drive && o_io_rdata == $past(i_iso_bit_data))
      else $error("isolation read not answered");
   a_cfg_restore: assert property (cmd_reset && !cmd_csn_clr |=>
      cfg_ff[CFG_IO_HI] == CFG_RST[CFG_IO_HI] && !o_dev_active && csn_ff == $past(csn_ff))
      else $error("reset command did not restore");
   a_key_return: assert property (cmd_wait_key && !cmd_csn_clr |=>
      state_ff == ST_WAIT_KEY && csn_ff == $past(csn_ff))
      else $error("wait key command failed");
   a_csn_clear: assert property (cmd_csn_clr |=> csn_ff == CSN_RST && saved_ff == CSN_RST)
      else $error("card number not cleared");
   a_wake_move: assert property (wake_match |=>
      state_ff == (($past(i_io_wdata) == 8'h00) ? ST_ISOLATE : ST_CONFIG))
      else $error("wake went to wrong state");
   a_res_advance: assert property (res_take |=> !res_ready ##1 o_res_fetch_req)
      else $error("resource byte not consumed");
   a_status_bit: assert property (rd_pnp && index_ff == IDX_STATUS |=>
      o_io_rdata[STATUS_RDY_BIT] == $past(res_ready))
      else $error("status bit wrong");
   a_csn_saved: assert property (wr_csn |=> csn_ff == $past(i_io_wdata) && saved_ff == csn_ff)
      else $error("saved card number mismatch");
   a_active_gate: assert property (o_dev_active |-> !rd_range)
      else $error("range check while active");
   a_range_answer: assert property (rd_range |=>
      o_io_rd_drive && o_io_rdata == ($past(rchk_pat) ? RCHK_PAT_SET : RCHK_PAT_CLR))
      else $error("range check pattern wrong");
   a_irq_type: assert property (rd_pnp && index_ff == IDX_IRQ_TYPE |=>
      o_io_rdata == IRQ_TYPE_VALUE)
      else $error("irq type not fixed");

   // Fixed reads and masked fields; the mask is the only way into a field
   a_ldn_fixed: assert property (rd_pnp && index_ff == IDX_LDN |=>
      o_io_rdata == LDN_VALUE)
      else $error("logical device number not zero");
   a_memctl_fixed: assert property (rd_pnp && index_ff == IDX_MEMCTL |=>
      o_io_rdata == MEMCTL_VALUE)
      else $error("memory control not zero");
   a_ctrl_reads_zero: assert property (rd_pnp && index_ff == IDX_CTRL |=>
      o_io_rdata == 8'h00)
      else $error("write-only index read back data");
   a_saved_read: assert property (rd_pnp && index_ff == IDX_SAVED_CSN |=>
      o_io_rdata == $past(saved_ff))
      else $error("saved card number read wrong");
   a_act_store: assert property (wr_cfg && index_ff == CFG_INDEX[CFG_ACT] |=>
      o_dev_active == $past(i_io_wdata[ACT_BIT]))
      else $error("activate bit not stored");
   a_irq_store: assert property (wr_cfg && index_ff == CFG_INDEX[CFG_IRQ] |=>
      o_irq_level == $past(i_io_wdata[3:0]) && o_irq_selected == (o_irq_level != 4'h0))
      else $error("irq level not stored");
   a_rom_size_kept: assert property (wr_cfg |=>
      o_boot_rom_size == $past(i_rom_size_cfg))
      else $error("boot rom size not from settings");
   a_rom_high_bits: assert property (o_boot_rom_base[23:20] == 4'h0 &&
      !o_boot_rom_base[17])
      else $error("boot rom high fixed bits set");
   a_rom_low_bits: assert property (o_boot_rom_base[13:8] == 6'h00)
      else $error("boot rom low fixed bits set");
   a_io_zero_bits: assert property (o_io_base[15:10] == 6'h00 &&
      o_io_base[4:0] == 5'h00)
      else $error("io base fixed bits set");

   a_drive_follows: assert property (o_io_rd_drive |-> $past(i_io_rd))
      else $error("read answered without a read");
   a_wake_restart: assert property (wake_match |=>
      !res_ready && o_res_fetch_addr == '0)
      else $error("resource read not restarted on wake");

   c_wake_config: cover property (wake_match && i_io_wdata != 8'h00);
   c_res_read: cover property (res_take ##[1:20] res_take);
   c_range_check: cover property (rd_range && !rchk_pat);
   c_iso_read: cover property (o_iso_compare);
   c_cfg_reset: cover property (cmd_reset);

endmodule

// ===== verif/ipcr_byte_store.sv
// Resource byte store model answering the prefetcher's fetch requests.
// Assumes one clock; delay input sets how many idle cycles precede each ack.
`timescale 1ns/1ns
module ipcr_byte_store (
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   // Fetch interface
   input  wire logic       i_req,
   input  wire logic [8:0] i_addr,
   input  wire logic [3:0] i_delay,
   output logic            o_ack,
   output logic [7:0]      o_byte
);
   logic [3:0] cnt_ff;

   // Byte line toggles outside acks so stale data never looks valid
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cnt_ff <= 4'h0;
         o_ack  <= 1'b0;
         o_byte <= 8'h00;
      end else if (!i_req || o_ack) begin
         cnt_ff <= 4'h0;
         o_ack  <= 1'b0;
         o_byte <= ~o_byte;
      end else if (cnt_ff == i_delay) begin
         o_ack  <= 1'b1;
         o_byte <= i_addr[7:0] ^ 8'h5A;
      end else begin
         cnt_ff <= cnt_ff + 4'h1;
         o_byte <= ~o_byte;
      end
   end
endmodule

// ===== verif/tb.sv
// Self-checking bench for the plug and play register bank.
// Assumes the host side is driven here and the byte store model sits beside.
`timescale 1ns/1ns
module tb;
   import ipcr_pkg::*;
   localparam logic [15:0] RPORT = 16'h0203;
   logic        i_clk = 1'b0;
   logic        i_rst = 1'b1;
   logic [15:0] io_addr = 16'h0000;
   logic [7:0]  io_wdata = 8'h00;
   logic        io_wr = 1'b0;
   logic        io_rd = 1'b0;
   logic        key = 1'b0;
   logic [7:0]  iso_data = 8'h00;
   logic [1:0]  rom_cfg = 2'h2;
   logic [3:0]  delay = 4'h0;
   logic [7:0]  rdata;
   logic        drive;
   logic        iso_cmp;
   logic        last_cmp;
   logic        f_req;
   logic        f_ack;
   logic [8:0]  f_addr;
   logic [7:0]  f_byte;
   ipcr_state_e card_state;
   logic        dev_active;
   logic [15:0] io_base;
   logic [3:0]  irq_level;
   logic        irq_sel;
   logic [23:8] rom_base;
   logic [1:0]  rom_size;
   logic [7:0]  card_select_number;
   logic [7:0]  saved;
   int          err_count = 0;
   int          total_checks = 0;

   always #20 i_clk = ~i_clk;

   ipcr_top ipcr_top_inst (.i_clk(i_clk), .i_rst(i_rst), .i_io_addr(io_addr),
      .i_io_wdata(io_wdata), .i_io_wr(io_wr), .i_io_rd(io_rd), .o_io_rdata(rdata),
      .o_io_rd_drive(drive), .i_key_match(key), .o_iso_compare(iso_cmp),
      .i_iso_bit_data(iso_data), .o_res_fetch_req(f_req), .o_res_fetch_addr(f_addr),
      .i_res_fetch_ack(f_ack), .i_res_fetch_byte(f_byte), .i_rom_size_cfg(rom_cfg),
      .o_card_state(card_state), .o_dev_active(dev_active), .o_io_base(io_base),
      .o_irq_level(irq_level), .o_irq_selected(irq_sel), .o_boot_rom_base(rom_base),
      .o_boot_rom_size(rom_size), .o_card_number(card_select_number), .o_saved_card_number(saved));

   ipcr_byte_store ipcr_byte_store_inst (.i_clk(i_clk), .i_rst(i_rst), .i_req(f_req),
      .i_addr(f_addr), .i_delay(delay), .o_ack(f_ack), .o_byte(f_byte));

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic put(input logic [15:0] a, input logic [7:0] d);
      @(posedge i_clk);
      io_addr <= a;
      io_wdata <= d;
      io_wr <= 1'b1;
      @(posedge i_clk);
      io_wr <= 1'b0;
      #1;
   endtask

   task automatic get(input logic [15:0] a, output logic [7:0] d, output logic dv);
      @(posedge i_clk);
      io_addr <= a;
      io_rd <= 1'b1;
      #1 last_cmp = iso_cmp;
      @(posedge i_clk);
      io_rd <= 1'b0;
      #1 d = rdata;
      dv = drive;
   endtask

   task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
      put(ADDR_PORT, {8'h00, idx});
      put(WDATA_PORT, d);
   endtask

   task automatic rchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
      logic [7:0] d;
      logic       dv;
      put(ADDR_PORT, {8'h00, idx});
      get(RPORT, d, dv);
      chk({what, " drive"}, 16'h0001, {15'h0, dv});
      chk(what, {8'h00, exp}, {8'h00, d});
   endtask

   task automatic t_waitkey();
      logic [7:0] d;
      logic       dv;
      wreg(IDX_RDPORT, 8'h80);
      get(RPORT, d, dv);
      chk("refused read", 16'h0000, {15'h0, dv});
      chk("state", {14'h0, ST_WAIT_KEY}, {14'h0, card_state});
      chk("io base reset", 16'h0000, io_base);
      $display("test waitkey done");
   endtask

   task automatic t_isolate();
      logic [7:0] d;
      logic       dv;
      @(posedge i_clk) key <= 1'b1;
      @(posedge i_clk) key <= 1'b0;
      #1 chk("sleep", {14'h0, ST_SLEEP}, {14'h0, card_state});
      wreg(IDX_WAKE, 8'h00);
      chk("isolate", {14'h0, ST_ISOLATE}, {14'h0, card_state});
      wreg(IDX_RDPORT, 8'h80);
      @(posedge i_clk) iso_data <= 8'hA5;
      rchk("serial", IDX_ISOLATE, 8'hA5);
      chk("compare", 16'h0001, {15'h0, last_cmp});
      get(RPORT, d, dv);
      chk("reread", 16'h00A5, {8'h00, d});
      get(16'h0200, d, dv);
      chk("low bits", 16'h0000, {15'h0, dv});
      $display("test isolate done");
   endtask

   task automatic t_csn();
      wreg(IDX_CSN, 8'h05);
      chk("csn", 16'h0005, {8'h00, card_select_number});
      chk("saved", 16'h0005, {8'h00, saved});
      rchk("csn rd", IDX_CSN, 8'h05);
      rchk("saved rd", IDX_SAVED_CSN, 8'h05);
      rchk("ldn", IDX_LDN, LDN_VALUE);
      rchk("memctl", IDX_MEMCTL, 8'h00);
      rchk("irqtype", IDX_IRQ_TYPE, 8'h02);
      wreg(8'h20, 8'hFF);
      rchk("undef", 8'h20, 8'h00);
      $display("test csn done");
   endtask

   task automatic t_cfg();
      for (int i = 0; i < CFG_N; i++) begin
         wreg(CFG_INDEX[i], 8'hFF);
         rchk("cfg", CFG_INDEX[i], CFG_MASK[i]);
      end
      chk("io base", 16'h03E0, io_base);
      chk("rom base", 16'h0DC0, rom_base);
      chk("irq", 16'h000F, {12'h0, irq_level});
      chk("active", 16'h0001, {15'h0, dev_active});
      chk("rom size", {14'h0, rom_cfg}, {14'h0, rom_size});
      @(posedge i_clk) rom_cfg <= 2'h1;
      repeat (2) @(posedge i_clk);
      #1 chk("rom size2", 16'h0001, {14'h0, rom_size});
      wreg(8'h70, 8'h00);
      chk("irq none", 16'h0000, {15'h0, irq_sel});
      $display("test cfg done");
   endtask

   task automatic t_range();
      logic [7:0] d;
      logic       dv;
      wreg(8'h30, 8'h00);
      wreg(8'h31, 8'h03);
      get(16'h03E4, d, dv);
      chk("pat55", 16'h0155, {7'h0, dv, d});
      wreg(8'h31, 8'h02);
      get(16'h03FF, d, dv);
      chk("patAA", 16'h01AA, {7'h0, dv, d});
      wreg(8'h31, 8'h01);
      get(16'h03E4, d, dv);
      chk("chk off", 16'h0000, {15'h0, dv});
      wreg(8'h31, 8'h00);
      wreg(8'h30, 8'h01);
      $display("test range done");
   endtask

   task automatic t_resource();
      logic [7:0] d;
      logic       dv;
      int         n;
      wreg(IDX_CTRL, 8'h02);
      chk("waitkey", {14'h0, ST_WAIT_KEY}, {14'h0, card_state});
      chk("csn kept", 16'h0005, {8'h00, card_select_number});
      @(posedge i_clk) key <= 1'b1;
      @(posedge i_clk) key <= 1'b0;
      wreg(IDX_WAKE, 8'h07);
      chk("no wake", {14'h0, ST_SLEEP}, {14'h0, card_state});
      delay <= 4'hA;
      wreg(IDX_WAKE, 8'h05);
      chk("config", {14'h0, ST_CONFIG}, {14'h0, card_state});
      for (int k = 0; k < 4; k++) begin
         put(ADDR_PORT, {8'h00, IDX_STATUS});
         d = 8'h00;
         n = 0;
         while (d[0] !== 1'b1 && n < 60) begin
            get(RPORT, d, dv);
            n++;
         end
         if (n >= 60) begin
            chk("status poll", 16'h0001, 16'h0000);
            complete_run();
         end
         rchk("res byte", IDX_RES_DATA, k[7:0] ^ 8'h5A);
         // Slow store leaves the buffer empty here; a zero-delay one has refilled it
         rchk("status", IDX_STATUS, (k < 2) ? 8'h00 : 8'h01);
         if (k == 1)
            delay <= 4'h0;
      end
      $display("test resource done");
   endtask

   task automatic t_ctrl();
      wreg(8'h70, 8'h05);
      wreg(IDX_CTRL, 8'h01);
      chk("cfg reset", 16'h0000, {12'h0, irq_level});
      chk("csn kept", 16'h0005, {8'h00, card_select_number});
      chk("state kept", {14'h0, ST_CONFIG}, {14'h0, card_state});
      wreg(IDX_CTRL, 8'h04);
      chk("csn clr", 16'h0000, {card_select_number, saved});
      wreg(IDX_CSN, 8'h09);
      repeat (3) @(posedge i_clk);
      #1 chk("no repeat", 16'h0909, {card_select_number, saved});
      rchk("ctrl rd", IDX_CTRL, 8'h00);
      $display("test ctrl done");
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      repeat (20) @(posedge i_clk);
      i_rst <= 1'b0;
      t_waitkey();
      t_isolate();
      t_csn();
      t_cfg();
      t_range();
      t_resource();
      t_ctrl();
      complete_run();
   end
endmodule
